//--- src/t1_ctrl_pkg.sv
`default_nettype none
package t1_ctrl_pkg;

    // parallel control port byte addresses
    localparam logic [7:0] ADDR_A_CTRL5 = 8'h19;
    localparam logic [7:0] ADDR_A_CTRL6 = 8'h1E;
    localparam logic [7:0] ADDR_B_CTRL5 = 8'hB9;

    // field positions
    localparam int BIT_ALT_CRC6 = 7;
    localparam int BIT_LOOPBACK = 6;
    localparam int BIT_ALL_ONES = 5;
    localparam int BIT_ACCUM_MODE = 6;
    localparam int BIT_MANUAL_UPD = 5;
    localparam int CHAN_MSB = 4;
    localparam int CHAN_LSB = 0;

    // reset value and writable bits of framer b ctrl5
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] B_CTRL5_MASK = 8'h9F;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // manual update settling time
    localparam int CLK_PERIOD_NS = 25;
    localparam int MANUAL_WAIT_NS = 972;
    localparam int MANUAL_WAIT_CYC =
        (MANUAL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W = 6;

    // automatic accumulation periods, in frames, with the fast one also in ms
    localparam int ACCUM_FAST_MS = 42;
    localparam int ACCUM_FAST_FRAMES = 333;
    localparam int ACCUM_SLOW_FRAMES = 8000;
    localparam int FRAME_W = 13;

    // all-ones bit rate divider from the master clock
    localparam int AIS_DIV = 26;
    localparam int AIS_W = 5;

    typedef struct packed {
        logic valid;
        logic [4:0] chan;
        logic [7:0] data;
    } chan_byte_s;

endpackage
`default_nettype wire

//--- src/chan_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module chan_monitor
    import t1_ctrl_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // selection and stream
    input wire logic [4:0] i_sel,
    input wire chan_byte_s i_byte,
    // captured byte
    output logic [7:0] o_mon
);

    // holds until the selected channel comes round again
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mon <= CTRL_RESET;
        end else if (i_byte.valid && i_byte.chan == i_sel) begin
            o_mon <= i_byte.data;
        end
    end

endmodule // chan_monitor
`default_nettype wire

//--- src/t1_framer_ctrl_regs_5_6.sv
// Functional notes
// - tx crc6 bit picks alternate transmit calculation
// - framer b has independent ctrl5 copy
// - local loopback bit enables loopback when set
// - all-ones bit forces unframed ones onto line
// - all-ones timing comes from master clock
// - tx channel field selects monitored transmit channel
// - field bit 4 msb, bit 0 lsb
// - rx crc6 bit picks alternate receive check
// - accumulation mode selects ctrl3 or manual bit
// - manual rising edge loads counters next cycle
// - ctrl3 fast bit updates every 333 frames
// - rx channel field selects monitored receive channel
`timescale 1ns/1ps
`default_nettype none
module t1_framer_ctrl_regs_5_6
    import t1_ctrl_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // parallel control port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // transmit line path, framer a
    input wire logic i_tx_pos_input_a,
    input wire logic i_tx_neg_input_a,
    output logic o_line_tx_tip,
    output logic o_line_tx_ring,
    // channel streams and monitors
    input wire chan_byte_s i_tx_byte_a,
    input wire chan_byte_s i_tx_byte_b,
    input wire chan_byte_s i_rx_byte_a,
    output logic [7:0] o_tx_channel_monitor_reg_a,
    output logic [7:0] o_tx_channel_monitor_reg_b,
    output logic [7:0] o_rx_channel_monitor_reg_a,
    // framer controls
    output logic o_tx_alt_crc6_select_a,
    output logic o_tx_alt_crc6_select_b,
    output logic o_rx_alt_crc6_select_a,
    output logic o_local_loopback_enable_a,
    // error accumulation timing
    input wire logic i_framer_a_ctrl3_fast,
    input wire logic i_rx_frame_a,
    output logic o_err_count_load_a,
    output logic o_err_count_settling_a
);

    logic [7:0] framer_a_ctrl5;
    logic [7:0] framer_a_ctrl6;
    logic [7:0] framer_b_ctrl5;
    logic manual_prev;
    logic manual_rise;
    logic [WAIT_W-1:0] wait_cnt;
    logic [FRAME_W-1:0] frame_cnt;
    logic [FRAME_W-1:0] frame_last;
    logic auto_hit;
    logic [AIS_W-1:0] ais_cnt;
    logic ais_bit_en;
    logic ais_phase;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            framer_a_ctrl5 <= CTRL_RESET;
            framer_a_ctrl6 <= CTRL_RESET;
            framer_b_ctrl5 <= CTRL_RESET;
        end else if (i_wr) begin
            if (i_addr == ADDR_A_CTRL5) begin
                framer_a_ctrl5 <= i_wdata;
            end
            if (i_addr == ADDR_A_CTRL6) begin
                framer_a_ctrl6 <= i_wdata;
            end
            // unassigned bits kept at zero whatever is written
            if (i_addr == ADDR_B_CTRL5) begin
                framer_b_ctrl5 <= i_wdata & B_CTRL5_MASK;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= RDATA_UNMAPPED;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_A_CTRL5: o_rdata <= framer_a_ctrl5;
                ADDR_A_CTRL6: o_rdata <= framer_a_ctrl6;
                ADDR_B_CTRL5: o_rdata <= framer_b_ctrl5;
                default: o_rdata <= RDATA_UNMAPPED;
            endcase
        end
    end

    assign o_tx_alt_crc6_select_a = framer_a_ctrl5[BIT_ALT_CRC6];
    assign o_tx_alt_crc6_select_b = framer_b_ctrl5[BIT_ALT_CRC6];
    assign o_rx_alt_crc6_select_a = framer_a_ctrl6[BIT_ALT_CRC6];
    assign o_local_loopback_enable_a = framer_a_ctrl5[BIT_LOOPBACK];

    // all-ones bit rate from the system (master) clock, never the tx clock
    assign ais_bit_en = (ais_cnt == AIS_W'(AIS_DIV - 1));

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ais_cnt <= '0;
            ais_phase <= 1'b0;
        end else if (ais_bit_en) begin
            ais_cnt <= '0;
            ais_phase <= ~ais_phase;
        end else begin
            ais_cnt <= ais_cnt + AIS_W'(1);
        end
    end

    // bipolar ones: every bit a mark, alternating rails
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_line_tx_tip <= 1'b0;
            o_line_tx_ring <= 1'b0;
        end else if (framer_a_ctrl5[BIT_ALL_ONES]) begin
            o_line_tx_tip <= ais_phase;
            o_line_tx_ring <= ~ais_phase;
        end else begin
            o_line_tx_tip <= i_tx_pos_input_a;
            o_line_tx_ring <= i_tx_neg_input_a;
        end
    end

    chan_monitor u_tx_mon_a (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_sel(framer_a_ctrl5[CHAN_MSB:CHAN_LSB]),
        .i_byte(i_tx_byte_a),
        .o_mon(o_tx_channel_monitor_reg_a)
    );

    chan_monitor u_tx_mon_b (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_sel(framer_b_ctrl5[CHAN_MSB:CHAN_LSB]),
        .i_byte(i_tx_byte_b),
        .o_mon(o_tx_channel_monitor_reg_b)
    );

    chan_monitor u_rx_mon_a (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_sel(framer_a_ctrl6[CHAN_MSB:CHAN_LSB]),
        .i_byte(i_rx_byte_a),
        .o_mon(o_rx_channel_monitor_reg_a)
    );

    // edge is taken against the stored bit, so only a written 0-to-1 counts
    assign manual_rise = framer_a_ctrl6[BIT_ACCUM_MODE]
        && framer_a_ctrl6[BIT_MANUAL_UPD] && !manual_prev;

    assign frame_last = i_framer_a_ctrl3_fast
        ? FRAME_W'(ACCUM_FAST_FRAMES - 1)
        : FRAME_W'(ACCUM_SLOW_FRAMES - 1);
    assign auto_hit = !framer_a_ctrl6[BIT_ACCUM_MODE] && i_rx_frame_a
        && frame_cnt >= frame_last;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            manual_prev <= 1'b0;
        end else begin
            manual_prev <= framer_a_ctrl6[BIT_MANUAL_UPD];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            frame_cnt <= '0;
        end else if (framer_a_ctrl6[BIT_ACCUM_MODE] || auto_hit) begin
            frame_cnt <= '0;
        end else if (i_rx_frame_a) begin
            frame_cnt <= frame_cnt + FRAME_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_err_count_load_a <= 1'b0;
        end else begin
            o_err_count_load_a <= manual_rise || auto_hit;
        end
    end

    // settling flag spans the least wait before counts may be read
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_cnt <= '0;
            o_err_count_settling_a <= 1'b0;
        end else if (manual_rise) begin
            wait_cnt <= WAIT_W'(MANUAL_WAIT_CYC);
            o_err_count_settling_a <= 1'b1;
        end else if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - WAIT_W'(1);
            o_err_count_settling_a <= (wait_cnt != WAIT_W'(1));
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    tx_crc_wr_a: assert property (
        i_wr && i_addr == ADDR_A_CTRL5 |=>
        o_tx_alt_crc6_select_a == $past(i_wdata[BIT_ALT_CRC6]))
        else $error("tx crc6 select a not written");

    b_indep_a: assert property (
        i_wr && i_addr != ADDR_B_CTRL5 |=> $stable(framer_b_ctrl5)
        && framer_b_ctrl5[BIT_LOOPBACK] == 1'b0)
        else $error("framer b ctrl5 changed by other write");

    loopback_wr_a: assert property (
        i_wr && i_addr == ADDR_A_CTRL5 |=>
        o_local_loopback_enable_a == $past(i_wdata[BIT_LOOPBACK]))
        else $error("loopback enable not written");

    ais_drive_a: assert property (
        $past(framer_a_ctrl5[BIT_ALL_ONES]) |->
        o_line_tx_tip != o_line_tx_ring)
        else $error("all-ones not driven on line");

    line_pass_a: assert property (
        !$past(framer_a_ctrl5[BIT_ALL_ONES]) |->
        o_line_tx_tip == $past(i_tx_pos_input_a)
        && o_line_tx_ring == $past(i_tx_neg_input_a))
        else $error("line data not passed through");

    ais_rate_a: assert property (
        framer_a_ctrl5[BIT_ALL_ONES] && $past(framer_a_ctrl5[BIT_ALL_ONES])
        && !$past(ais_bit_en) |=> $stable(o_line_tx_tip))
        else $error("all-ones mark changed off bit boundary");

    tx_select_a: assert property (
        i_tx_byte_a.valid
        && i_tx_byte_a.chan == framer_a_ctrl5[CHAN_MSB:CHAN_LSB] |=>
        o_tx_channel_monitor_reg_a == $past(i_tx_byte_a.data))
        else $error("tx monitor missed selected channel");

    rx_crc_wr_a: assert property (
        i_wr && i_addr == ADDR_A_CTRL6 |=>
        o_rx_alt_crc6_select_a == $past(i_wdata[BIT_ALT_CRC6]))
        else $error("rx crc6 select not written");

    manual_load_a: assert property (
        framer_a_ctrl6[BIT_ACCUM_MODE] && $rose(framer_a_ctrl6[BIT_MANUAL_UPD])
        |=> o_err_count_load_a ##1 o_err_count_settling_a[*8])
        else $error("manual update did not load and settle");

    fast_period_a: assert property (
        !framer_a_ctrl6[BIT_ACCUM_MODE] && i_framer_a_ctrl3_fast
        && i_rx_frame_a && frame_cnt == FRAME_W'(ACCUM_FAST_FRAMES - 1)
        |=> o_err_count_load_a && frame_cnt == '0)
        else $error("fast accumulation period wrong");

    rx_select_a: assert property (
        i_rx_byte_a.valid
        && i_rx_byte_a.chan == framer_a_ctrl6[CHAN_MSB:CHAN_LSB] |=>
        o_rx_channel_monitor_reg_a == $past(i_rx_byte_a.data))
        else $error("rx monitor missed selected channel");

    mon_hold_a: assert property (
        !(i_tx_byte_b.valid
        && i_tx_byte_b.chan == framer_b_ctrl5[CHAN_MSB:CHAN_LSB])
        |=> $stable(o_tx_channel_monitor_reg_b))
        else $error("tx monitor b changed without its channel");

    cover_ais_c: cover property (framer_a_ctrl5[BIT_ALL_ONES] [*8]);
    cover_manual_c: cover property (manual_rise ##1 o_err_count_load_a);
    cover_auto_c: cover property (auto_hit ##1 o_err_count_load_a);
    cover_mon_c: cover property ($changed(o_rx_channel_monitor_reg_a));

endmodule // t1_framer_ctrl_regs_5_6
`default_nettype wire

//--- verif/t1_framer_ctrl_regs_5_6_tb.sv
`timescale 1ns/1ps
`default_nettype none
module t1_framer_ctrl_regs_5_6_tb
    import t1_ctrl_pkg::*;
;
    logic clk, rst, wr, rd, pos, neg, fast, frame;
    logic [7:0] addr, wdata, rdata, mon_ta, mon_tb, mon_ra;
    logic tip, ring, crc_ta, crc_tb, crc_ra, lpb, load, settle;
    chan_byte_s sb;
    int error_cnt, n_tests, cyc;

    // one stream feeds all three monitors; selects tell them apart
    t1_framer_ctrl_regs_5_6 t1_framer_ctrl_regs_5_6_inst (
        .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_tx_pos_input_a(pos), .i_tx_neg_input_a(neg),
        .o_line_tx_tip(tip), .o_line_tx_ring(ring),
        .i_tx_byte_a(sb), .i_tx_byte_b(sb), .i_rx_byte_a(sb),
        .o_tx_channel_monitor_reg_a(mon_ta),
        .o_tx_channel_monitor_reg_b(mon_tb),
        .o_rx_channel_monitor_reg_a(mon_ra),
        .o_tx_alt_crc6_select_a(crc_ta), .o_tx_alt_crc6_select_b(crc_tb),
        .o_rx_alt_crc6_select_a(crc_ra), .o_local_loopback_enable_a(lpb),
        .i_framer_a_ctrl3_fast(fast), .i_rx_frame_a(frame),
        .o_err_count_load_a(load), .o_err_count_settling_a(settle)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 16800 cycles of the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 25000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check(rdata, exp);
    endtask

    task automatic send(input logic [4:0] ch, input logic [7:0] d);
        @(negedge clk);
        sb = '{valid: 1'b1, chan: ch, data: d};
        @(negedge clk);
        sb.valid = 1'b0;
    endtask

    task automatic t_regs;
        rd_chk(ADDR_A_CTRL5, CTRL_RESET);
        rd_chk(ADDR_A_CTRL6, CTRL_RESET);
        rd_chk(ADDR_B_CTRL5, CTRL_RESET);
        wr_reg(ADDR_A_CTRL5, 8'hA0);
        check(8'(crc_ta), 8'h01);
        check(8'(lpb), 8'h00);
        rd_chk(ADDR_A_CTRL5, 8'hA0);
        wr_reg(ADDR_A_CTRL5, 8'h40);
        check(8'(lpb), 8'h01);
        check(8'(crc_ta), 8'h00);
        // unassigned bits of framer b written as zero
        wr_reg(ADDR_B_CTRL5, 8'h9F);
        rd_chk(ADDR_B_CTRL5, 8'h9F);
        check(8'(crc_tb), 8'h01);
        check(8'(crc_ta), 8'h00);
        wr_reg(ADDR_A_CTRL6, 8'h80);
        check(8'(crc_ra), 8'h01);
        rd_chk(ADDR_A_CTRL6, 8'h80);
        wr_reg(8'h55, 8'hFF);
        rd_chk(8'h55, RDATA_UNMAPPED);
        rd_chk(ADDR_A_CTRL5, 8'h40);
    endtask

    task automatic t_line;
        logic prev;
        int k;
        wr_reg(ADDR_A_CTRL5, 8'h00);
        pos = 1'b1;
        @(negedge clk);
        check(8'(tip), 8'h01);
        check(8'(ring), 8'h00);
        pos = 1'b0;
        neg = 1'b1;
        @(negedge clk);
        check(8'({tip, ring}), 8'h01);
        neg = 1'b0;
        wr_reg(ADDR_A_CTRL5, 8'h20);
        // first edge only swaps pass-through for a mark, not a real flip
        @(negedge clk);
        // phase is free running, so skip to a flip before timing one
        prev = tip;
        k = 0;
        while (tip === prev && k < 60) begin
            @(negedge clk);
            k++;
        end
        prev = tip;
        k = 0;
        while (tip === prev && k < 60) begin
            check(8'(ring), 8'(!tip));
            @(negedge clk);
            k++;
        end
        check(8'(k), 8'(AIS_DIV));
        wr_reg(ADDR_A_CTRL5, 8'h00);
    endtask

    task automatic t_mon;
        wr_reg(ADDR_A_CTRL5, 8'h10);
        wr_reg(ADDR_B_CTRL5, 8'h01);
        wr_reg(ADDR_A_CTRL6, 8'h11);
        send(5'd16, 8'h5A);
        check(mon_ta, 8'h5A);
        check(mon_tb, 8'h00);
        check(mon_ra, 8'h00);
        send(5'd1, 8'hC3);
        check(mon_tb, 8'hC3);
        check(mon_ta, 8'h5A);
        send(5'd17, 8'h3C);
        check(mon_ra, 8'h3C);
        check(mon_tb, 8'hC3);
    endtask

    task automatic t_manual;
        int k;
        wr_reg(ADDR_A_CTRL6, 8'h00);
        wr_reg(ADDR_A_CTRL6, 8'h20);
        @(negedge clk);
        check(8'(load), 8'h00);
        wr_reg(ADDR_A_CTRL6, 8'h40);
        wr_reg(ADDR_A_CTRL6, 8'h60);
        check(8'(load), 8'h00);
        @(negedge clk);
        check(8'(load), 8'h01);
        k = 0;
        while (settle === 1'b1 && k < 100) begin
            k++;
            @(negedge clk);
        end
        check(8'(k), 8'(MANUAL_WAIT_CYC));
        wr_reg(ADDR_A_CTRL6, 8'h60);
        @(negedge clk);
        check(8'(load), 8'h00);
    endtask

    task automatic t_auto;
        int early, total;
        early = 0;
        total = 0;
        wr_reg(ADDR_A_CTRL6, 8'h00);
        fast = 1'b1;
        for (int i = 1; i <= ACCUM_FAST_FRAMES; i++) begin
            @(negedge clk);
            frame = 1'b1;
            @(negedge clk);
            frame = 1'b0;
            total += int'(load);
            if (i < ACCUM_FAST_FRAMES) begin
                early += int'(load);
            end
        end
        repeat (3) begin
            @(negedge clk);
            total += int'(load);
        end
        check(8'(early), 8'h00);
        check(8'(total), 8'h01);
    endtask

    // slow period: the only load must come on the last frame
    task automatic t_auto_slow;
        int first, total;
        first = 0;
        total = 0;
        fast = 1'b0;
        for (int i = 1; i <= ACCUM_SLOW_FRAMES; i++) begin
            @(negedge clk);
            frame = 1'b1;
            @(negedge clk);
            frame = 1'b0;
            if (load === 1'b1) begin
                total++;
                if (first == 0) begin
                    first = i;
                end
            end
        end
        check(8'(first == ACCUM_SLOW_FRAMES), 8'h01);
        check(8'(total), 8'h01);
    endtask

    initial begin
        rst = 1'b1;
        {wr, rd, pos, neg, fast, frame} = 6'h00;
        addr = 8'h00;
        wdata = 8'h00;
        sb = '0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_line();
        t_mon();
        t_manual();
        t_auto();
        t_auto_slow();
        report_and_stop();
    end
endmodule // t1_framer_ctrl_regs_5_6_tb
`default_nettype wire
